/* File: fsp_pkg.sv */
// shared constants and carrier types of the flash self-program control
package fsp_pkg;

    // ======================================================
    // register placement
    localparam logic [7:0] DATA_ADDR = 8'h57; // data-space offset
    localparam logic [7:0] IO_ADDR = 8'h37; // i/o-space offset
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ======================================================
    // control register bit positions
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_CONC_BUSY = 6;
    localparam int BIT_SIG_READ = 5;
    localparam int BIT_REENABLE = 4;
    localparam int BIT_LOCK_SET = 3;
    localparam int BIT_PAGE_WRITE = 2;
    localparam int BIT_PAGE_ERASE = 1;
    localparam int BIT_STORE_EN = 0;

    // ======================================================
    // accepted command codes, bits 5..0 of a register write
    localparam logic [5:0] CMD_SIG_READ = 6'h21;
    localparam logic [5:0] CMD_REENABLE = 6'h11;
    localparam logic [5:0] CMD_LOCK_SET = 6'h09;
    localparam logic [5:0] CMD_PAGE_WRITE = 6'h05;
    localparam logic [5:0] CMD_PAGE_ERASE = 6'h03;
    localparam logic [5:0] CMD_BUF_LOAD = 6'h01;

    // ======================================================
    // arming windows in core clock cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;

    // ======================================================
    // lock byte layout and value after reset
    localparam logic [7:0] LOCK_RESET = 8'hFF;
    localparam logic [7:0] LOCK_WRITABLE = 8'h3F; // bits 7,6 unused
    localparam int LOCK_MEM_LO = 0;
    localparam int LOCK_MEM_HI = 1;

    // ======================================================
    // first page of the halting section
    localparam logic [7:0] HALT_FIRST_PAGE = 8'hE0;

    // core instruction request towards the sequencer
    typedef struct packed {
        logic store; // store program memory instruction
        logic load; // load program memory instruction
        logic [15:0] z_ptr; // z pointer
        logic [7:0] low_data; // low data register
        logic [7:0] high_data; // high data register
    } fsp_cpu_req_s;

    // commands to the flash array and temporary buffer
    typedef struct packed {
        logic erase; // page erase start pulse
        logic write; // page write start pulse
        logic lock_write; // lock programming start pulse
        logic [7:0] page; // page select
        logic buf_wr; // buffer word load pulse
        logic buf_discard; // drop buffer content pulse
        logic [6:0] buf_idx; // buffer word index
        logic [15:0] buf_wdata; // buffer word
    } fsp_flash_cmd_s;

    // protection levels seen by the external programming ports
    typedef struct packed {
        logic prog_refuse; // flash/eeprom programming refused
        logic verify_refuse; // flash/eeprom verification refused
        logic fuse_locked; // fuse changes refused
        logic boot_lock_locked; // boot lock bits frozen
    } fsp_protect_s;

    typedef enum logic [2:0] {
        FSP_IDLE = 3'b001,
        FSP_ARMED = 3'b010,
        FSP_BUSY = 3'b100
    } fsp_state_e;

endpackage

/* File: fsp_ctrl.sv */
// flash self-program control and status register with its sequencer
`timescale 1ns/1ns
`default_nettype none

module fsp_ctrl (
    input wire logic core_clk, // core clock, 25 MHz
    input wire logic rstn, // async reset, active low
    input wire logic io_space, // address is an i/o offset
    input wire logic [7:0] io_addr, // register address
    input wire logic io_wr, // register write strobe
    input wire logic [7:0] io_wdata, // register write data
    output logic [7:0] io_rdata, // register read data
    input wire logic gie, // global interrupt enable
    input wire fsp_pkg::fsp_cpu_req_s cpu_req, // core instruction
    input wire logic [7:0] sig_data, // signature row byte
    input wire logic [7:0] fuse_data, // fuse byte for readback
    input wire logic flash_done, // array operation finished
    input wire logic chip_erase, // chip erase pulse
    output fsp_pkg::fsp_flash_cmd_s flash_cmd, // array commands
    output logic [7:0] load_data, // special load result
    output logic load_valid, // load_data overrides flash read
    output logic irq_req, // store ready interrupt request
    output logic cpu_stall, // core halted
    output logic conc_read_block, // concurrent section blocked
    output logic [7:0] lock_byte, // current lock bits
    output fsp_pkg::fsp_protect_s protect // external port protection
);

    // ======================================================
    // state record
    typedef struct packed {
        fsp_pkg::fsp_state_e state;
        logic [7:0] ctrl; // control and status register
        logic [2:0] age; // cycles since arming
        logic [7:0] lock; // lock byte
        logic buf_loaded; // buffer holds unwritten words
        logic op_halt; // running op targets halting section
        logic [7:0] load_data;
        logic load_valid;
        fsp_pkg::fsp_flash_cmd_s cmd;
    } fsp_regs_s;

    fsp_regs_s q;
    fsp_regs_s next_q;

    // ======================================================
    // helpers
    function automatic logic reg_hit(input logic space,
                                     input logic [7:0] addr);
        reg_hit = space ? (addr == fsp_pkg::IO_ADDR)
                        : (addr == fsp_pkg::DATA_ADDR);
    endfunction

    function automatic logic cmd_ok(input logic [5:0] cmd);
        cmd_ok = (cmd == fsp_pkg::CMD_SIG_READ) ||
                 (cmd == fsp_pkg::CMD_REENABLE) ||
                 (cmd == fsp_pkg::CMD_LOCK_SET) ||
                 (cmd == fsp_pkg::CMD_PAGE_WRITE) ||
                 (cmd == fsp_pkg::CMD_PAGE_ERASE) ||
                 (cmd == fsp_pkg::CMD_BUF_LOAD);
    endfunction

    logic hit;
    logic store_ok;
    logic load_ok;
    logic [5:0] armed_cmd;

    assign hit = reg_hit(io_space, io_addr);
    assign armed_cmd = q.ctrl[5:0];
    // store accepted only inside the window
    assign store_ok = (q.state == fsp_pkg::FSP_ARMED) &&
                      (q.age < fsp_pkg::STORE_WINDOW);
    assign load_ok = (q.state == fsp_pkg::FSP_ARMED) &&
                     (q.age < fsp_pkg::LOAD_WINDOW);

    // ======================================================
    // next state
    always_comb begin
        next_q = q;
        next_q.cmd.erase = 1'b0;
        next_q.cmd.write = 1'b0;
        next_q.cmd.lock_write = 1'b0;
        next_q.cmd.buf_wr = 1'b0;
        next_q.cmd.buf_discard = 1'b0;
        next_q.load_valid = 1'b0;

        // arming window ages only while armed
        if (q.state == fsp_pkg::FSP_ARMED) begin
            next_q.age = q.age + 3'h1;
        end

        if (q.state == fsp_pkg::FSP_ARMED &&
            q.age == fsp_pkg::STORE_WINDOW - 3'h1) begin
            next_q.ctrl[5:0] = 6'h00;
            next_q.state = fsp_pkg::FSP_IDLE;
        end

        if (cpu_req.load && load_ok &&
            armed_cmd == fsp_pkg::CMD_SIG_READ) begin
            next_q.load_data = sig_data;
            next_q.load_valid = 1'b1;
        end
        // z0 picks lock or fuse byte
        if (cpu_req.load && load_ok &&
            armed_cmd == fsp_pkg::CMD_LOCK_SET) begin
            next_q.load_data = cpu_req.z_ptr[0] ? q.lock : fuse_data;
            next_q.load_valid = 1'b1;
        end

        // stores outside the window fall through here
        if (cpu_req.store && store_ok) begin
            unique case (armed_cmd)
                fsp_pkg::CMD_SIG_READ: begin
                    next_q.state = q.state;
                end
                fsp_pkg::CMD_REENABLE: begin
                    next_q.ctrl[fsp_pkg::BIT_CONC_BUSY] = 1'b0;
                    next_q.ctrl[5:0] = 6'h00;
                    next_q.state = fsp_pkg::FSP_IDLE;
                end
                fsp_pkg::CMD_LOCK_SET: begin
                    // only low data, programmed bits stay 0
                    next_q.lock = q.lock & (cpu_req.low_data |
                                            ~fsp_pkg::LOCK_WRITABLE);
                    next_q.cmd.lock_write = 1'b1;
                    // a store at the last window cycle keeps bits
                    next_q.ctrl[5:0] = q.ctrl[5:0];
                    next_q.state = fsp_pkg::FSP_BUSY;
                end
                fsp_pkg::CMD_PAGE_WRITE,
                fsp_pkg::CMD_PAGE_ERASE: begin
                    next_q.cmd.page = cpu_req.z_ptr[15:8];
                    next_q.cmd.write =
                        (armed_cmd == fsp_pkg::CMD_PAGE_WRITE);
                    next_q.cmd.erase =
                        (armed_cmd == fsp_pkg::CMD_PAGE_ERASE);
                    next_q.op_halt = (cpu_req.z_ptr[15:8] >=
                                      fsp_pkg::HALT_FIRST_PAGE);
                    if (cpu_req.z_ptr[15:8] < fsp_pkg::HALT_FIRST_PAGE) begin
                        next_q.ctrl[fsp_pkg::BIT_CONC_BUSY] = 1'b1;
                    end
                    if (armed_cmd == fsp_pkg::CMD_PAGE_WRITE) begin
                        next_q.buf_loaded = 1'b0;
                    end
                    // timeout above must not drop store enable
                    next_q.ctrl[5:0] = q.ctrl[5:0];
                    next_q.state = fsp_pkg::FSP_BUSY;
                end
                fsp_pkg::CMD_BUF_LOAD: begin
                    // word address z 7:1, z0 ignored
                    next_q.cmd.buf_wr = 1'b1;
                    next_q.cmd.buf_idx = cpu_req.z_ptr[7:1];
                    next_q.cmd.buf_wdata = {cpu_req.high_data,
                                            cpu_req.low_data};
                    next_q.buf_loaded = 1'b1;
                    next_q.ctrl[fsp_pkg::BIT_CONC_BUSY] = 1'b0;
                    next_q.ctrl[5:0] = 6'h00;
                    next_q.state = fsp_pkg::FSP_IDLE;
                end
                default: begin
                    next_q.state = q.state;
                end
            endcase
        end

        if (q.state == fsp_pkg::FSP_BUSY && flash_done) begin
            next_q.ctrl[5:0] = 6'h00;
            next_q.op_halt = 1'b0;
            next_q.state = fsp_pkg::FSP_IDLE;
        end

        // register write; command field only when not busy
        if (io_wr && hit) begin
            next_q.ctrl[fsp_pkg::BIT_IRQ_EN] =
                io_wdata[fsp_pkg::BIT_IRQ_EN];
            // refused while erase or write in progress
            if (q.state != fsp_pkg::FSP_BUSY && cmd_ok(io_wdata[5:0])) begin
                next_q.ctrl[5:0] = io_wdata[5:0];
                next_q.age = 3'h0;
                next_q.state = fsp_pkg::FSP_ARMED;
                if (io_wdata[5:0] == fsp_pkg::CMD_REENABLE &&
                    q.buf_loaded) begin
                    next_q.cmd.buf_discard = 1'b1;
                    next_q.buf_loaded = 1'b0;
                end
            end
        end

        // only chip erase or reset returns lock bits to one
        if (chip_erase) begin
            next_q.lock = fsp_pkg::LOCK_RESET;
        end
    end

    // ======================================================
    // state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q.state <= fsp_pkg::FSP_IDLE;
            q.ctrl <= fsp_pkg::CTRL_RESET;
            q.age <= 3'h0;
            q.lock <= fsp_pkg::LOCK_RESET;
            q.buf_loaded <= 1'b0;
            q.op_halt <= 1'b0;
            q.load_data <= 8'h00;
            q.load_valid <= 1'b0;
            q.cmd <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ======================================================
    // outputs
    // read data is a mux of flops; no read side effects exist
    assign io_rdata = hit ? q.ctrl : 8'h00;
    assign flash_cmd = q.cmd;
    assign load_data = q.load_data;
    assign load_valid = q.load_valid;
    assign lock_byte = q.lock;

    // level request while store enable is clear
    assign irq_req = q.ctrl[fsp_pkg::BIT_IRQ_EN] && gie &&
                     !q.ctrl[fsp_pkg::BIT_STORE_EN];

    // stall for the whole halting-section operation
    assign cpu_stall = (q.state == fsp_pkg::FSP_BUSY) && q.op_halt;

    // reads blocked while the flag is set
    assign conc_read_block = q.ctrl[fsp_pkg::BIT_CONC_BUSY];

    // memory lock pair sits in bits 1..0
    // mode two, low bit programmed only
    always_comb begin
        protect.prog_refuse = !q.lock[fsp_pkg::LOCK_MEM_LO] ||
                              !q.lock[fsp_pkg::LOCK_MEM_HI];
        protect.fuse_locked = protect.prog_refuse;
        protect.verify_refuse = !q.lock[fsp_pkg::LOCK_MEM_LO] &&
                                !q.lock[fsp_pkg::LOCK_MEM_HI];
        protect.boot_lock_locked = protect.verify_refuse;
    end

endmodule

`default_nettype wire

/* File: fsp_ctrl_asserts.sv */
// port checker for the flash self-program control
`timescale 1ns/1ns
`default_nettype none

module fsp_ctrl_asserts (
    input wire logic core_clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic io_space, // i/o offset select
    input wire logic [7:0] io_addr, // register address
    input wire logic io_wr, // write strobe
    input wire logic [7:0] io_wdata, // write data
    input wire logic gie, // global irq enable
    input wire fsp_pkg::fsp_cpu_req_s cpu_req, // core instruction
    input wire logic chip_erase, // chip erase pulse
    input wire fsp_pkg::fsp_flash_cmd_s flash_cmd, // array commands
    input wire logic load_valid, // special load result
    input wire logic irq_req, // store ready request
    input wire logic cpu_stall, // core halted
    input wire logic conc_read_block, // section blocked
    input wire logic [7:0] lock_byte, // lock bits
    input wire fsp_pkg::fsp_protect_s protect // protection levels
);
    logic hit;
    logic ops;
    logic pg_op;
    // ==================================================
    // decode helpers
    assign hit = io_wr && io_addr == (io_space ? 8'h37 : 8'h57);
    assign pg_op = flash_cmd.erase || flash_cmd.write;
    assign ops = pg_op || flash_cmd.lock_write || flash_cmd.buf_wr;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // signature arming followed by a store inside the window
    sequence sig_store;
        hit && io_wdata[5:0] == 6'h21 ##[1:4] cpu_req.store;
    endsequence
    // buffer-load arming left idle past four cycles, then a store
    sequence late_store;
        hit && io_wdata[5:0] == 6'h01
            ##1 (!cpu_req.store && !io_wr)[*4] ##1 cpu_req.store;
    endsequence

    // ==================================================
    // assertions
    a_irq_needs_gie: assert property (!gie |-> !irq_req)
        else $error("store ready request without global enable");
    a_erase_sets_busy: assert property (
        flash_cmd.erase && flash_cmd.page < 8'hE0 |-> conc_read_block)
        else $error("section not blocked during erase");
    a_load_clears_busy: assert property (
        flash_cmd.buf_wr |-> !conc_read_block)
        else $error("busy flag kept across buffer load");
    a_load_needs_req: assert property (
        load_valid |-> $past(cpu_req.load))
        else $error("load result without load");
    a_sig_store_void: assert property (sig_store |=> !ops)
        else $error("store after signature arming acted");
    a_word_from_ptr: assert property (
        cpu_req.store ##1 flash_cmd.buf_wr |->
        flash_cmd.buf_idx == $past(cpu_req.z_ptr[7:1]) &&
        flash_cmd.buf_wdata ==
        $past({cpu_req.high_data, cpu_req.low_data}))
        else $error("buffer word or index wrong");
    a_page_from_ptr: assert property (
        pg_op |-> flash_cmd.page == $past(cpu_req.z_ptr[15:8]))
        else $error("page select not from pointer");
    a_halt_stalls: assert property (
        pg_op && flash_cmd.page >= 8'hE0 |-> cpu_stall)
        else $error("core not stalled for halting section");
    a_window_lapse: assert property (
        late_store |=> !flash_cmd.buf_wr)
        else $error("store accepted after window");
    a_store_cause: assert property (ops |-> $past(cpu_req.store))
        else $error("array command without store");
    a_lock_restore: assert property (
        $rose(lock_byte[0]) |-> $past(chip_erase))
        else $error("lock bit erased without chip erase");
    a_unused_ones: assert property (lock_byte[7:6] == 2'b11)
        else $error("unused lock bits programmed");
    a_mode_two: assert property (
        lock_byte[1:0] == 2'b10 |-> protect == 4'hA)
        else $error("mode two protection wrong");
    a_mode_three: assert property (
        lock_byte[1:0] == 2'b00 |-> protect == 4'hF)
        else $error("mode three protection wrong");
endmodule

bind fsp_ctrl fsp_ctrl_asserts chk_u (
    .core_clk(core_clk), .rstn(rstn), .io_space(io_space),
    .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .gie(gie),
    .cpu_req(cpu_req), .chip_erase(chip_erase), .flash_cmd(flash_cmd),
    .load_valid(load_valid), .irq_req(irq_req), .cpu_stall(cpu_stall),
    .conc_read_block(conc_read_block), .lock_byte(lock_byte),
    .protect(protect)
);
`default_nettype wire

/* File: fsp_flash_model.sv */
// behavioural flash array answering erase, write and lock programming
`timescale 1ns/1ns
`default_nettype none

module fsp_flash_model #(
    parameter int DONE_DELAY = 10
) (
    input wire logic core_clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire fsp_pkg::fsp_flash_cmd_s flash_cmd, // array commands
    output logic flash_done // operation finished pulse
);
    int count;
    // completion ends busy hold
    // short fixed delay stands in for the slow array time
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (count == 1);
            if (flash_cmd.erase || flash_cmd.write || flash_cmd.lock_write)
                count <= DONE_DELAY;
            else if (count != 0)
                count <= count - 1;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the flash self-program control
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic core_clk, rstn, io_space, io_wr, gie, chip_erase, flash_done;
    logic load_valid, irq_req, cpu_stall, conc_read_block, lv;
    logic [7:0] io_addr, io_wdata, io_rdata, load_data, lock_byte, ldv;
    fsp_pkg::fsp_cpu_req_s cpu_req;
    fsp_pkg::fsp_flash_cmd_s flash_cmd;
    fsp_pkg::fsp_protect_s protect;
    int fails = 0;
    int total_checks = 0;
    int n_op = 0;
    int n_disc = 0;
    int cyc = 0;
    logic [7:0] lapse [0:5] = '{8'h89, 8'h85, 8'h83, 8'h81, 8'hA1, 8'h91};
    logic [7:0] bad [0:3] = '{8'h82, 8'h87, 8'h93, 8'hBF};

    fsp_ctrl dut_u (
        .core_clk(core_clk), .rstn(rstn), .io_space(io_space),
        .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .gie(gie), .cpu_req(cpu_req),
        .sig_data(8'h5A), .fuse_data(8'hA5), .flash_done(flash_done),
        .chip_erase(chip_erase), .flash_cmd(flash_cmd),
        .load_data(load_data), .load_valid(load_valid), .irq_req(irq_req),
        .cpu_stall(cpu_stall), .conc_read_block(conc_read_block),
        .lock_byte(lock_byte), .protect(protect)
    );
    fsp_flash_model flash_u (.core_clk(core_clk), .rstn(rstn),
        .flash_cmd(flash_cmd), .flash_done(flash_done));

    // ==================================================
    // clock, watchdog and pulse counters
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // pulses last one cycle, so they are counted rather than sampled
    always @(posedge core_clk) begin
        cyc++;
        if ((flash_cmd.erase | flash_cmd.write | flash_cmd.lock_write |
            flash_cmd.buf_wr) === 1'b1) n_op++;
        if (flash_cmd.buf_discard === 1'b1) n_disc++;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish;
        end
    end

    // ==================================================
    // access tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge core_clk);
        io_space <= 1'b0;
        io_addr <= 8'h57;
        io_wr <= 1'b1;
        io_wdata <= d;
        @(posedge core_clk);
        io_wr <= 1'b0;
    endtask
    task automatic rd(input logic s, input logic [7:0] a, logic [7:0] e);
        @(posedge core_clk);
        io_space <= s;
        io_addr <= a;
        @(negedge core_clk);
        chk(io_rdata, e);
    endtask
    // one store or load; the load answer is caught in its one cycle
    task automatic op(input logic st, input logic [15:0] z, logic [15:0] d);
        @(posedge core_clk);
        cpu_req <= {st, ~st, z, d[7:0], d[15:8]};
        @(posedge core_clk);
        cpu_req <= '0;
        @(negedge core_clk);
        lv = load_valid;
        ldv = load_data;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic settle;
        for (int i = 0; i < 60 && io_rdata[0] !== 1'b0; i++)
            @(negedge core_clk);
        chk(io_rdata[0], 1'b0);
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==================================================
    // main sequence
    initial begin
        rstn = 1'b0;
        {io_space, io_wr, chip_erase} = 3'h0;
        gie = 1'b1;
        io_addr = 8'h57;
        io_wdata = 8'h00;
        cpu_req = '0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        rd(1'b0, 8'h57, 8'h00);
        rd(1'b1, 8'h37, 8'h00);
        rd(1'b1, 8'h38, 8'h00);
        chk(lock_byte, 8'hFF);
        wr(8'h80);
        rd(1'b1, 8'h37, 8'h80);
        chk(irq_req, 1'b1);
        @(posedge core_clk);
        gie <= 1'b0;
        @(negedge core_clk);
        chk(irq_req, 1'b0);
        @(posedge core_clk);
        gie <= 1'b1;
        wr(8'h81);
        op(1'b1, 16'h0012, 16'h1234);
        chk({flash_cmd.buf_idx, flash_cmd.buf_wdata}, 23'h091234);
        rd(1'b0, 8'h57, 8'h80);
        wr(8'h83);
        op(1'b1, 16'h1000, 16'h0000);
        chk(flash_cmd.page, 8'h10);
        rd(1'b0, 8'h57, 8'hC3);
        chk({conc_read_block, irq_req}, 2'b10);
        wr(8'h91);
        rd(1'b0, 8'h57, 8'hC3);
        settle;
        rd(1'b0, 8'h57, 8'hC0);
        wr(8'h91);
        op(1'b1, 16'h0000, 16'h0000);
        chk({conc_read_block, io_rdata}, 9'h080);
        chk(n_disc, 1);
        wr(8'h83);
        op(1'b1, 16'h2000, 16'h0000);
        settle;
        wr(8'h81);
        op(1'b1, 16'h0002, 16'hBEEF);
        chk({conc_read_block, n_op[7:0]}, 9'h004);
        wr(8'h85);
        op(1'b1, 16'hE000, 16'h0000);
        chk({cpu_stall, flash_cmd.page}, 9'h1E0);
        settle;
        chk({cpu_stall, n_op[7:0]}, 9'h005);
        for (int i = 0; i < 6; i++) begin
            wr(lapse[i]);
            // store lands one cycle past the four-cycle window
            repeat (4) @(negedge core_clk);
            op(1'b1, 16'h0000, 16'h0000);
            rd(1'b0, 8'h57, 8'h80);
        end
        for (int i = 0; i < 4; i++) begin
            wr(bad[i]);
            rd(1'b0, 8'h57, 8'h80);
        end
        op(1'b1, 16'h0000, 16'h0000);
        chk(n_op, 5);
        wr(8'hA1);
        op(1'b0, 16'h0000, 16'h0000);
        chk({lv, ldv}, 9'h15A);
        wr(8'hA1);
        op(1'b1, 16'h0000, 16'h0000);
        chk(n_op, 5);
        wr(8'h89);
        op(1'b0, 16'h0001, 16'h0000);
        chk({lv, ldv}, 9'h1FF);
        wr(8'h89);
        op(1'b0, 16'h0000, 16'h0000);
        chk({lv, ldv}, 9'h1A5);
        wr(8'h89);
        op(1'b1, 16'hFFFF, 16'h55FE);
        settle;
        chk({lock_byte, protect}, 12'hFEA);
        wr(8'h89);
        op(1'b1, 16'h0000, 16'h00FC);
        settle;
        chk({lock_byte, protect}, 12'hFCF);
        @(posedge core_clk);
        chip_erase <= 1'b1;
        @(posedge core_clk);
        chip_erase <= 1'b0;
        @(negedge core_clk);
        chk({lock_byte, protect, n_op[3:0]}, 16'hFF07);
        // erase stored at the last cycle of its window
        wr(8'h83);
        repeat (3) @(negedge core_clk);
        op(1'b1, 16'h3000, 16'h0000);
        rd(1'b0, 8'h57, 8'hC3);
        settle;
        rd(1'b0, 8'h57, 8'hC0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
